// file: logic/sotf_map.svh
// Register offsets, field widths, reset values and timing constants of the timing filter
`ifndef SOTF_MAP_SVH
`define SOTF_MAP_SVH

`define SOTF_REG_CTRL    8'h00
`define SOTF_REG_CYCLE   8'h04
`define SOTF_REG_BEAMS   8'h08
`define SOTF_REG_EDGES   8'h0c
`define SOTF_REG_OUTS    8'h10
`define SOTF_REG_OUT0    8'h20
`define SOTF_OUT_SHIFT   3
`define SOTF_DEPTH_W     8
`define SOTF_DEPTH_RST   8'h01
`define SOTF_CYCLE_RST   16'h03e8
`define SOTF_DUR_MAX_MS  16'hfde8
`define SOTF_US_PER_MS   27'h00003e8
`define SOTF_EL_W        27
`define SOTF_RESP_OKAY   2'h0
`define SOTF_RESP_DECERR 2'h3

`endif

// file: logic/sotf_pkg.sv
// Shared types of the switching output timing filter
package sotf_pkg;

	typedef enum logic [2:0] {
		SOTF_TF_NONE,
		SOTF_TF_START,
		SOTF_TF_OFF,
		SOTF_TF_STRETCH,
		SOTF_TF_SUPPRESS
	} sotf_tfunc_t;

	typedef struct packed {
		logic [7:0]  end_beam;
		logic [7:0]  start_beam;
		logic [1:0]  spare;
		logic        track;
		logic        and_sel;
		logic        dark;
		sotf_tfunc_t func;
	} sotf_ocfg_t;

endpackage

// file: logic/sotf_timer.sv
// Time function of one switching output, stepped once per measurement cycle
`timescale 1ns/1ps
`include "sotf_map.svh"

module sotf_timer (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 meas_tick,
	input  wire sotf_pkg::sotf_tfunc_t func,
	input  wire logic [15:0]          dur_ms,
	input  wire logic [15:0]          cycle_us,
	input  wire logic                 dark,
	input  wire logic                 det,
	output logic                      sw_out
);
	import sotf_pkg::*;

	typedef struct packed {
		logic                  out;
		logic                  fresh;
		logic [`SOTF_EL_W-1:0] el;
	} sotf_tmr_st_t;

	sotf_tmr_st_t          st;
	sotf_tmr_st_t          next_st;
	logic [`SOTF_EL_W-1:0] lim;
	logic [`SOTF_EL_W-1:0] inc;
	logic [`SOTF_EL_W:0]   sum;

	// Elapsed time grows by one measurement period per tick, so resolution is the cycle
	assign lim = `SOTF_EL_W'(dur_ms) * `SOTF_US_PER_MS;
	assign sum = {1'b0, st.el} + (`SOTF_EL_W+1)'(cycle_us);
	assign inc = sum[`SOTF_EL_W] ? '1 : sum[`SOTF_EL_W-1:0];

	always_comb begin
		next_st = st;
		if (meas_tick) begin
			case (func)
				SOTF_TF_START: begin
					if (!det) begin
						next_st.out = 1'b0;
						next_st.el  = '0;
					end else if (!st.out) begin
						if (inc >= lim) begin
							next_st.out = 1'b1;
							next_st.el  = '0;
						end else begin
							next_st.el = inc;
						end
					end
				end
				SOTF_TF_OFF: begin
					if (det) begin
						next_st.out = 1'b1;
						next_st.el  = '0;
					end else if (st.out) begin
						if (inc >= lim) begin
							next_st.out = 1'b0;
							next_st.el  = '0;
						end else begin
							next_st.el = inc;
						end
					end
				end
				SOTF_TF_STRETCH: begin
					if (det != st.out && (st.fresh || st.el >= lim)) begin
						next_st.out = det;
						next_st.el  = '0;
					end else begin
						next_st.el = inc;
					end
				end
				SOTF_TF_SUPPRESS: begin
					if (det == st.out) begin
						next_st.el = '0;
					end else if (inc >= lim) begin
						next_st.out = det;
						next_st.el  = '0;
					end else begin
						next_st.el = inc;
					end
				end
				default: begin
					next_st.out = det;
					next_st.el  = '0;
				end
			endcase
			next_st.fresh = st.fresh & (next_st.out == st.out);
		end
	end

	// Fresh holds until the first switch, so a stretch output follows its first change at once
	// Elapsed starts at zero so start and suppress delays still count on the first detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{out: 1'b0, fresh: 1'b1, el: '0};
		end else begin
			st <= next_st;
		end
	end

	// Light switching drives the output while nothing is detected
	assign sw_out = st.out ^ ~dark;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_tick_only_step: assert property (!meas_tick |=> $stable(st.out))
		else $error("output moved outside a measurement tick");
	a_start_needs_det: assert property (func == SOTF_TF_START && $rose(st.out) |-> $past(det))
		else $error("start delay fired without detection");
	a_off_holds_on: assert property (func == SOTF_TF_OFF && st.out && det |=> st.out)
		else $error("switch-off delay dropped while detecting");
	a_stretch_keeps: assert property (func == SOTF_TF_STRETCH && $changed(st.out)
		&& `SOTF_EL_W'(cycle_us) < lim |=> $stable(st.out))
		else $error("stretched state not kept");
	a_suppress_follow: assert property (func == SOTF_TF_SUPPRESS && $changed(st.out)
		|-> st.out == $past(det))
		else $error("suppressed output took a value not present");

endmodule // sotf_timer

// file: logic/sotf_filter.sv
// Beam filter, area evaluation and per-output timing with an AXI4-Lite register slave
`timescale 1ns/1ps
`include "sotf_map.svh"

module sotf_filter #(
	parameter int NB = 32,
	parameter int NO = 4
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          meas_tick,
	input  wire logic [NB-1:0] beam_raw,
	output logic [NO-1:0]      sw_out,
	input  wire logic [7:0]    s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [7:0]    s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready
);
	import sotf_pkg::*;

	typedef struct packed {
		logic [`SOTF_DEPTH_W-1:0]         depth;
		logic [15:0]                      cycle_us;
		sotf_ocfg_t [NO-1:0]              cfg;
		logic [NO-1:0][15:0]              dur;
		logic [NB-1:0]                    beams;
		logic [NB-1:0][`SOTF_DEPTH_W-1:0] cnt;
		logic                             awh;
		logic                             wh;
		logic [7:0]                       awaddr;
		logic [31:0]                      wdata;
		logic [3:0]                       wstrb;
		logic                             bvalid;
		logic [1:0]                       bresp;
		logic                             rvalid;
		logic [31:0]                      rdata;
		logic [1:0]                       rresp;
	} sotf_state_t;

	sotf_state_t                      s;
	sotf_state_t                      next_s;
	logic [NB-1:0]                    nb_beam;
	logic [NB-1:0][`SOTF_DEPTH_W-1:0] nb_cnt;
	logic [7:0]                       first_blocked_beam;
	logic [7:0]                       last_blocked_beam;
	logic                             any_blocked;
	logic [NO-1:0]                    area_stat;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			merge[8*i +: 8] = be[i] ? d[8*i +: 8] : old[8*i +: 8];
		end
	endfunction

	// Output slot of an address, or NO when the address is no output register
	function automatic int out_slot(input logic [7:0] a);
		logic [7:0] off;
		off = a - `SOTF_REG_OUT0;
		if (a < `SOTF_REG_OUT0 || int'(off >> `SOTF_OUT_SHIFT) >= NO) begin
			return NO;
		end
		return int'(off >> `SOTF_OUT_SHIFT);
	endfunction

	// A beam flips only after depth ticks that all disagree with its accepted state
	for (genvar b = 0; b < NB; b++) begin : g_beam
		logic hit;
		assign hit = (s.cnt[b] + 8'h01) >= s.depth;
		assign nb_beam[b] = (meas_tick && beam_raw[b] != s.beams[b] && hit) ?
			beam_raw[b] : s.beams[b];
		assign nb_cnt[b] = !meas_tick ? s.cnt[b] :
			(beam_raw[b] == s.beams[b] || hit) ? '0 : s.cnt[b] + 8'h01;
	end

	always_comb begin
		first_blocked_beam = '0;
		last_blocked_beam  = '0;
		any_blocked        = 1'b0;
		for (int i = NB - 1; i >= 0; i--) begin
			if (s.beams[i]) begin
				first_blocked_beam = 8'(i);
				any_blocked        = 1'b1;
			end
		end
		for (int i = 0; i < NB; i++) begin
			if (s.beams[i]) begin
				last_blocked_beam = 8'(i);
			end
		end
	end

	// An empty tracked area never counts as all blocked, so a lost web reads as a hole
	always_comb begin
		logic [7:0] lo;
		logic [7:0] hi;
		logic       all_b;
		logic       one_b;
		logic       in_r;
		lo    = '0;
		hi    = '0;
		all_b = 1'b0;
		one_b = 1'b0;
		in_r  = 1'b0;
		for (int k = 0; k < NO; k++) begin
			lo    = s.cfg[k].track ? first_blocked_beam : s.cfg[k].start_beam;
			hi    = s.cfg[k].track ? last_blocked_beam : s.cfg[k].end_beam;
			all_b = 1'b1;
			one_b = 1'b0;
			in_r  = 1'b0;
			for (int i = 0; i < NB; i++) begin
				if (8'(i) >= lo && 8'(i) <= hi) begin
					in_r  = 1'b1;
					all_b = all_b & s.beams[i];
					one_b = one_b | s.beams[i];
				end
			end
			area_stat[k] = s.cfg[k].and_sel ? (all_b & in_r) : one_b;
		end
	end

	for (genvar k = 0; k < NO; k++) begin : g_out
		sotf_timer u_timer (
			.clk       (clk),
			.rst_n     (rst_n),
			.meas_tick (meas_tick),
			.func      (s.cfg[k].func),
			.dur_ms    (s.dur[k]),
			.cycle_us  (s.cycle_us),
			.dark      (s.cfg[k].dark),
			.det       (area_stat[k]),
			.sw_out    (sw_out[k])
		);
	end

	always_comb begin
		logic [31:0] m;
		int          k;
		m      = '0;
		k      = 0;
		next_s = s;
		next_s.beams = nb_beam;
		next_s.cnt   = nb_cnt;
		if (s_axi_awvalid && s_axi_awready) begin
			next_s.awh    = 1'b1;
			next_s.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_s.wh    = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.awh && s.wh && !s.bvalid) begin
			next_s.awh    = 1'b0;
			next_s.wh     = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = `SOTF_RESP_OKAY;
			k = out_slot(s.awaddr);
			case ({2'b00, s.awaddr[7:2]})
				`SOTF_REG_CTRL >> 2: begin
					m            = merge(32'(s.depth), s.wdata, s.wstrb);
					next_s.depth = m[`SOTF_DEPTH_W-1:0];
				end
				`SOTF_REG_CYCLE >> 2: begin
					m               = merge(32'(s.cycle_us), s.wdata, s.wstrb);
					next_s.cycle_us = m[15:0];
				end
				`SOTF_REG_BEAMS >> 2, `SOTF_REG_EDGES >> 2, `SOTF_REG_OUTS >> 2: begin
					next_s.bresp = `SOTF_RESP_OKAY;
				end
				default: begin
					if (k == NO) begin
						next_s.bresp = `SOTF_RESP_DECERR;
					end else if (s.awaddr[2]) begin
						m = merge(32'(s.dur[k]), s.wdata, s.wstrb);
						next_s.dur[k] = (m[15:0] > `SOTF_DUR_MAX_MS) ?
							`SOTF_DUR_MAX_MS : m[15:0];
					end else begin
						m = merge(32'(s.cfg[k]), s.wdata, s.wstrb);
						next_s.cfg[k] = sotf_ocfg_t'(m[23:0]);
					end
				end
			endcase
		end
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = `SOTF_RESP_OKAY;
			next_s.rdata  = '0;
			k = out_slot(s_axi_araddr);
			case ({2'b00, s_axi_araddr[7:2]})
				`SOTF_REG_CTRL >> 2:  next_s.rdata = 32'(s.depth);
				`SOTF_REG_CYCLE >> 2: next_s.rdata = 32'(s.cycle_us);
				`SOTF_REG_BEAMS >> 2: next_s.rdata = 32'(s.beams);
				`SOTF_REG_EDGES >> 2: begin
					next_s.rdata = {15'h0000, any_blocked, last_blocked_beam, first_blocked_beam};
				end
				`SOTF_REG_OUTS >> 2:  next_s.rdata = 32'(sw_out);
				default: begin
					if (k == NO) begin
						next_s.rresp = `SOTF_RESP_DECERR;
					end else if (s_axi_araddr[2]) begin
						next_s.rdata = 32'(s.dur[k]);
					end else begin
						next_s.rdata = 32'(s.cfg[k]);
					end
				end
			endcase
		end
	end

	// Configuration resets to light switching, no time function and depth one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s          <= '0;
			s.depth    <= `SOTF_DEPTH_RST;
			s.cycle_us <= `SOTF_CYCLE_RST;
		end else begin
			s <= next_s;
		end
	end

	// One write and one read held; a new read address waits for the previous answer, a write address only for the held write to land
	assign s_axi_awready = !s.awh;
	assign s_axi_wready  = !s.wh;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_filter_on_tick: assert property (!meas_tick |=> $stable(s.beams))
		else $error("filtered beams moved without a tick");
	a_depth_one_pass: assert property (meas_tick && s.depth == 8'h01
		|=> s.beams == $past(beam_raw))
		else $error("depth one did not pass raw beams");
	a_depth_three_wait: assert property ($changed(s.beams[0]) && $past(s.depth) == 8'h03
		|-> $past(s.cnt[0]) == 8'h02 && $past(beam_raw[0], 1) == s.beams[0])
		else $error("depth three accepted an unstable beam");
	a_write_answer: assert property (s.bvalid && !s_axi_bready |=> s.bvalid && $stable(s.bresp))
		else $error("write response withdrawn");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s.rvalid)
		else $error("read not answered next cycle");
	a_and_full_area: assert property (!s.cfg[0].track && s.cfg[0].and_sel
		&& s.cfg[0].start_beam == 8'h00 && s.cfg[0].end_beam == 8'(NB - 1)
		|-> area_stat[0] == (&s.beams))
		else $error("AND area status wrong");
	a_track_empty: assert property (s.cfg[0].track && !any_blocked |-> !area_stat[0])
		else $error("tracked empty area reported blocked");

	a_write_lands: assert property (s.awh && s.wh && !s.bvalid |=> s.bvalid)
		else $error("held write not answered");
	// Only a polarity write may move an output between ticks
	a_out_tick_only: assert property (!meas_tick |=> $stable(sw_out) || $changed(s.cfg))
		else $error("switching output moved without a tick");
	a_edges_order: assert property (any_blocked |-> first_blocked_beam <= last_blocked_beam)
		else $error("first blocked beam above last blocked beam");

	c_depth_three: cover property (s.depth == 8'h03 && $changed(s.beams));
	c_write_done: cover property (s.bvalid && s_axi_bready);
	c_out_switch: cover property ($changed(sw_out));
	c_hole_seen: cover property (s.cfg[0].track && s.cfg[0].and_sel && $fell(area_stat[0]));
	c_decode_err: cover property (s.bvalid && s.bresp == `SOTF_RESP_DECERR);

endmodule // sotf_filter

// file: tb/sotf_plc_model.sv
// Controller model that scans the switching outputs at its own rate
`timescale 1ns/1ps

module sotf_plc_model #(
	parameter int NO   = 4,
	parameter int SCAN = 3
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic [NO-1:0] sw_out,
	output logic [NO-1:0]      image
);
	// Scans slower than the clock, so pulses shorter than SCAN may be missed
	int cnt;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt   <= 0;
			image <= '0;
		end else begin
			cnt <= (cnt == SCAN - 1) ? 0 : cnt + 1;
			if (cnt == 0)
				image <= sw_out;
		end
	end
endmodule // sotf_plc_model

// file: tb/tb_switch_output_timing_filter.sv
// Self-checking bench of the switching output timing filter
`timescale 1ns/1ps
`include "sotf_map.svh"

module tb_switch_output_timing_filter;
	import sotf_pkg::*;
	localparam int         NO = 4;
	localparam logic [1:0] OK = `SOTF_RESP_OKAY;
	localparam logic [1:0] DE = `SOTF_RESP_DECERR;
	logic          clk = 0;
	logic          rst_n = 0;
	logic          meas_tick = 0;
	logic [31:0]   beam_raw = '0;
	logic [NO-1:0] sw_out;
	logic [NO-1:0] image;
	logic [7:0]    awaddr = '0;
	logic [7:0]    araddr = '0;
	logic [31:0]   wdata = '0;
	logic          awvalid = 0;
	logic          wvalid = 0;
	logic          bready = 0;
	logic          arvalid = 0;
	logic          rready = 0;
	logic          awready, wready, bvalid, arready, rvalid;
	logic [1:0]    bresp, rresp;
	logic [31:0]   rdata;
	int            fails = 0;
	int            check_count = 0;
	int            cycles = 0;
	sotf_tfunc_t   fn[4] = '{SOTF_TF_STRETCH, SOTF_TF_START, SOTF_TF_OFF, SOTF_TF_SUPPRESS};
	int            du[4] = '{2, 3, 2, 2};
	// Outputs 0..3 watch beams 0..3; bit 0 at tick 3 sits on the stretch boundary
	logic [3:0]    raw_t[12] = '{4'hf, 4'h2, 4'h8, 4'ha, 4'he, 4'h2,
		4'he, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0};
	logic [3:0]    exp_t[12] = '{4'hf, 4'ha, 4'ha, 4'he, 4'h7, 4'h3,
		4'h1, 4'h1, 4'h3, 4'h7, 4'hf, 4'hf};

	sotf_filter #(.NB(32), .NO(NO)) i_sotf_filter (
		.clk(clk), .rst_n(rst_n), .meas_tick(meas_tick), .beam_raw(beam_raw), .sw_out(sw_out),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);

	sotf_plc_model #(.NO(NO), .SCAN(3)) i_sotf_plc_model (
		.clk(clk), .rst_n(rst_n), .sw_out(sw_out), .image(image)
	);

	always #10 clk = ~clk;

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			print_verdict();
		end
	end

	task print_verdict;
		if (fails == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Handshakes are judged at the falling edge, where values stand settled until the rising one
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic       aw_hs;
		logic       w_hs;
		logic       b_hs;
		logic [1:0] resp;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(negedge clk);
			aw_hs = awvalid && awready;
			w_hs  = wvalid && wready;
			b_hs  = (bvalid === 1'b1);
			resp  = bresp;
			@(posedge clk);
			if (aw_hs)
				awvalid <= 1'b0;
			if (w_hs)
				wvalid <= 1'b0;
		end while (!b_hs);
		bready <= 1'b0;
		cmp("bresp", 32'(er), 32'(resp));
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic        ar_hs;
		logic        r_hs;
		logic [31:0] data;
		logic [1:0]  resp;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(negedge clk);
			ar_hs = arvalid && arready;
			r_hs  = (rvalid === 1'b1);
			data  = rdata;
			resp  = rresp;
			@(posedge clk);
			if (ar_hs)
				arvalid <= 1'b0;
		end while (!r_hs);
		rready <= 1'b0;
		cmp("rdata", ed, data);
		cmp("rresp", 32'(er), 32'(resp));
	endtask

	task automatic tick(input logic [31:0] raw, input logic [3:0] e, input logic [3:0] m);
		@(posedge clk);
		meas_tick <= 1'b1;
		beam_raw  <= raw;
		@(posedge clk);
		meas_tick <= 1'b0;
		#1;
		if (m != 4'h0)
			cmp("sw_out", 32'(e & m), 32'(sw_out & m));
	endtask

	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		cmp("sw_out", 32'hf, 32'(sw_out));
		rd(`SOTF_REG_CTRL, 32'(`SOTF_DEPTH_RST), OK);
		rd(`SOTF_REG_CYCLE, 32'(`SOTF_CYCLE_RST), OK);
		rd(8'h40, 32'h0, DE);
		wr(8'h40, 32'h1, DE);
		wr(8'h24, 32'hffff, OK);
		rd(8'h24, 32'(`SOTF_DUR_MAX_MS), OK);
		for (int i = 0; i < NO; i++) begin
			wr(8'(`SOTF_REG_OUT0 + 8 * i), {8'h00, 8'(i), 8'(i), 5'h00, fn[i]}, OK);
			wr(8'(`SOTF_REG_OUT0 + 8 * i + 4), 32'(du[i]), OK);
		end
		for (int k = 0; k < 12; k++)
			tick(32'(raw_t[k]), exp_t[k], (k == 3) ? 4'he : 4'hf);
		tick(32'h28, 4'h0, 4'h0);
		rd(`SOTF_REG_BEAMS, 32'h28, OK);
		rd(`SOTF_REG_EDGES, 32'h00010503, OK);
		wr(`SOTF_REG_OUT0, 32'h30, OK);
		tick(32'h1c, 4'h0, 4'h0);
		tick(32'h1c, 4'h0, 4'h1);
		tick(32'h14, 4'h0, 4'h0);
		tick(32'h14, 4'h1, 4'h1);
		wr(`SOTF_REG_OUT0, 32'h38, OK);
		tick(32'h14, 4'h0, 4'h1);
		repeat (4) @(posedge clk);
		#1;
		cmp("image", 32'h0, 32'(image[0]));
		wr(`SOTF_REG_CTRL, 32'h3, OK);
		tick(32'h0, 4'h0, 4'h0);
		tick(32'h0, 4'h0, 4'h0);
		rd(`SOTF_REG_BEAMS, 32'h14, OK);
		tick(32'h0, 4'h0, 4'h0);
		rd(`SOTF_REG_BEAMS, 32'h0, OK);
		tick(32'h15, 4'h0, 4'h0);
		tick(32'h0, 4'h0, 4'h0);
		tick(32'h15, 4'h0, 4'h0);
		tick(32'h15, 4'h0, 4'h0);
		rd(`SOTF_REG_BEAMS, 32'h0, OK);
		tick(32'h15, 4'h0, 4'h0);
		rd(`SOTF_REG_BEAMS, 32'h15, OK);
		wr(`SOTF_REG_OUT0, 32'h001f0010, OK);
		tick(32'h15, 4'h1, 4'h1);
		repeat (3) tick(32'hffffffff, 4'h0, 4'h0);
		tick(32'hffffffff, 4'h0, 4'h1);
		print_verdict();
	end
endmodule // tb_switch_output_timing_filter
